/* File: rtl/cpm_move_unit.sv */
// Decoder and executor for coprocessor and product register moves
// Function
// RL1: Zero-extending load reserved in 32-bit user/supervisor
// RL2: System coprocessor read, sign-extend in 64-bit
// RL3: System coprocessor unusable outside kernel when disabled
// RL4: Generic read selects half, sign-extends result
// RL5: Decode coprocessor number, direction, zero fields
// RL6: Generic write; unusable coprocessor raises exception
// RL7: System write commits one cycle later
// RL8: Software avoids memory ops around system write
// RL9: Read upper product into rd
// RL10: No upper modifier in next two instructions
// RL11: Read bottom product into rd
// RL12: No bottom modifier in next two instructions
// RL13: Write upper product from source register
// RL14: Move after upper write spoils bottom
// RL15: Write bottom; later move spoils upper
// RL16: Signed 32-bit multiply, never overflow
// RL17: Product halves to bottom/upper, sign-extended; the code sign-extends only in 64-bit mode and zero-extends in 32-bit mode
// RL18: Two instructions between product read and multiply
// RL19: Software supplies sign-extended multiply operands
// RL20: Nonzero reserved fields give undefined result
`timescale 1ns/1ps
module cpm_move_unit
  import cpm_pkg::*;
#(
  parameter int COP_COUNT = 3
)
(
  clk,
  reset_n,
  issue,
  mode,
  mode64,
  cop_usable,
  cop_rdata,
  gpr_wr,
  cop_req,
  exc,
  product_upper,
  product_bottom
);
  input wire logic clk;
  input wire logic reset_n;
  input wire cpm_issue_t issue;
  input wire cpm_mode_t mode;
  input wire logic mode64;
  input wire logic [2:0] cop_usable;
  input wire logic [63:0] cop_rdata;
  output cpm_gpr_wr_t gpr_wr;
  output cpm_cop_req_t cop_req;
  output cpm_exc_t exc;
  output logic [63:0] product_upper;
  output logic [63:0] product_bottom;

  // Number field and usable mask cover at most three coprocessors
  if (COP_COUNT < 1 || COP_COUNT > 3) begin : g_cop_count_check
    $error("COP_COUNT must lie between 1 and 3");
  end

  typedef struct packed {
    logic rd_pend;
    logic rd_half;
    logic rd_sys;
    logic [4:0] rd_tgt;
    cpm_gpr_wr_t gw;
    cpm_cop_req_t cr;
    cpm_exc_t ex;
    logic [63:0] upper;
    logic [63:0] bottom;
    logic upper_wr_last;
    logic bottom_wr_last;
  } cpm_state_t;

  cpm_state_t st_ff;
  cpm_state_t nxt_st;

  // Reset image: product registers at their reset value, all else clear
  localparam cpm_state_t ST_RESET = '{upper: CPM_PRODUCT_RESET, bottom: CPM_PRODUCT_RESET, default: '0};

  // Low word, sign- or zero-extended to 64 bits
  function automatic logic [63:0] sext32(input logic [31:0] v, input logic m64);
    sext32 = m64 ? {{32{v[31]}}, v} : {32'h0, v};
  endfunction

  // True for the four product register move function codes
  function automatic logic prod_move_fn(input logic [5:0] f);
    prod_move_fn = f == CPM_FN_RD_UPPER || f == CPM_FN_WR_UPPER
      || f == CPM_FN_RD_BOTTOM || f == CPM_FN_WR_BOTTOM;
  endfunction

  // Index sent to a coprocessor; 64-bit generic reads address the even register
  function automatic logic [4:0] cop_index(input logic [4:0] rd, input logic [1:0] cop, input logic m64);
    cop_index = (m64 && cop != 2'h0) ? {rd[4:1], 1'b0} : rd;
  endfunction

  logic [5:0] op;
  logic [4:0] sub;
  logic [4:0] tgt_f;
  logic [4:0] rd_f;
  logic [5:0] fn;
  logic [1:0] cop_num;
  logic cop_ok;
  logic cop_zeros;
  logic is_cop_mv;
  logic user_like;
  logic cop_en;
  logic is_prod_mv;
  logic lwu_trap;
  logic is_signed_product_op;
  logic cop_wr;
  logic signed [63:0] prod;
  logic [31:0] prod_hi;
  logic [31:0] prod_lo;

  // Instruction fields
  assign op = issue.word[31:26];
  assign sub = issue.word[25:21];
  assign tgt_f = issue.word[20:16];
  assign rd_f = issue.word[15:11];
  assign fn = issue.word[5:0];
  assign cop_num = {issue.word[CPM_COP_NUM_HI], issue.word[CPM_COP_NUM_LO]}; // RL5
  // Coprocessor numbers beyond the supported count are not decoded
  assign cop_ok = {30'h0, cop_num} < COP_COUNT;
  assign cop_zeros = issue.word[10:0] == 11'h0;
  assign is_cop_mv = issue.valid && op[5:2] == CPM_OP_COP[5:2] && cop_ok && cop_zeros
    && (sub == CPM_SUB_MF || sub == CPM_SUB_MT); // RL5
  // Supervisor and user share the same privilege limits here
  assign user_like = mode != CPM_MODE_KERNEL;
  assign cop_en = cop_usable[cop_num] || (cop_num == 2'h0 && !user_like); // RL3 RL6
  assign is_prod_mv = issue.valid && op == CPM_OP_SPECIAL && prod_move_fn(fn);
  assign lwu_trap = issue.valid && op == CPM_OP_LWU && !mode64 && user_like; // RL1
  assign is_signed_product_op = issue.valid && op == CPM_OP_SPECIAL && fn == CPM_FN_SIGNED_PRODUCT; // RL16
  assign cop_wr = issue.word[CPM_DIR_BIT]; // RL5
  // Full 64-bit signed product; no overflow path exists
  assign prod = $signed(issue.src_val[31:0]) * $signed(issue.tgt_val[31:0]); // RL16
  assign prod_hi = prod[63:32];
  assign prod_lo = prod[31:0];

  always_comb begin
    nxt_st = st_ff;
    nxt_st.gw.we = 1'b0;
    nxt_st.cr.rd_en = 1'b0;
    nxt_st.cr.we = 1'b0;
    nxt_st.ex = '0;
    nxt_st.rd_pend = 1'b0;
    // Second cycle of a coprocessor read: answer stands on cop_rdata now
    if (st_ff.rd_pend) begin
      nxt_st.gw.we = 1'b1;
      nxt_st.gw.idx = st_ff.rd_tgt;
      if (st_ff.rd_sys || !mode64) begin
        nxt_st.gw.data = sext32(cop_rdata[31:0], mode64); // RL2
      end else begin
        nxt_st.gw.data = sext32(st_ff.rd_half ? cop_rdata[63:32] : cop_rdata[31:0], 1'b1); // RL4
      end
    end
    if (lwu_trap) begin
      nxt_st.ex.reserved_instr = 1'b1; // RL1
    end else if (is_cop_mv) begin
      if (!cop_en) begin
        nxt_st.ex.cop_unusable = 1'b1; // RL3 RL6
        nxt_st.ex.cop = cop_num;
      end else if (!cop_wr) begin
        nxt_st.cr.rd_en = 1'b1;
        nxt_st.cr.cop = cop_num;
        nxt_st.cr.idx = cop_index(rd_f, cop_num, mode64); // RL4
        nxt_st.rd_pend = 1'b1;
        nxt_st.rd_tgt = tgt_f;
        nxt_st.rd_half = rd_f[0];
        nxt_st.rd_sys = cop_num == 2'h0;
      end else begin
        nxt_st.cr.we = 1'b1; // RL6 RL7
        nxt_st.cr.cop = cop_num;
        nxt_st.cr.idx = rd_f;
        nxt_st.cr.data = issue.tgt_val;
      end
    end else if (is_signed_product_op) begin
      nxt_st.bottom = sext32(prod_lo, mode64); // RL17
      nxt_st.upper = sext32(prod_hi, mode64); // RL17
      nxt_st.upper_wr_last = 1'b0;
      nxt_st.bottom_wr_last = 1'b0;
    end else if (is_prod_mv) begin
      // A product read right behind a coprocessor read takes the write port
      // Reserved fields not checked; nonzero gives undefined result
      unique case (fn)
        CPM_FN_RD_UPPER: begin
          nxt_st.gw.we = 1'b1; // RL9 RL20
          nxt_st.gw.idx = rd_f;
          nxt_st.gw.data = st_ff.upper;
        end
        CPM_FN_RD_BOTTOM: begin
          nxt_st.gw.we = 1'b1; // RL11
          nxt_st.gw.idx = rd_f;
          nxt_st.gw.data = st_ff.bottom;
        end
        CPM_FN_WR_UPPER: begin
          nxt_st.upper = issue.src_val; // RL13
        end
        default: begin
          nxt_st.bottom = issue.src_val; // RL15
        end
      endcase
      // Other half left as is: undefined value permitted after a move
      nxt_st.upper_wr_last = fn == CPM_FN_WR_UPPER; // RL14
      nxt_st.bottom_wr_last = fn == CPM_FN_WR_BOTTOM; // RL15
    end
  end

  // Asynchronous reset; every pulse output drops at once
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Every output straight from the state register
  assign gpr_wr = st_ff.gw;
  assign cop_req = st_ff.cr;
  assign exc = st_ff.ex;
  assign product_upper = st_ff.upper;
  assign product_bottom = st_ff.bottom;
endmodule // cpm_move_unit

/* File: rtl/cpm_pkg.sv */
// Package for the coprocessor and product register move decoder
package cpm_pkg;
  localparam logic [5:0] CPM_OP_SPECIAL = 6'h00;
  localparam logic [5:0] CPM_OP_COP = 6'h10;
  localparam logic [5:0] CPM_OP_LWU = 6'h27;
  localparam logic [4:0] CPM_SUB_MF = 5'h00;
  localparam logic [4:0] CPM_SUB_MT = 5'h04;
  localparam logic [5:0] CPM_FN_RD_UPPER = 6'h10;
  localparam logic [5:0] CPM_FN_WR_UPPER = 6'h11;
  localparam logic [5:0] CPM_FN_RD_BOTTOM = 6'h12;
  localparam logic [5:0] CPM_FN_WR_BOTTOM = 6'h13;
  localparam logic [5:0] CPM_FN_SIGNED_PRODUCT = 6'h18;
  localparam int CPM_COP_NUM_HI = 27;
  localparam int CPM_COP_NUM_LO = 26;
  localparam int CPM_DIR_BIT = 23;
  localparam logic [63:0] CPM_PRODUCT_RESET = 64'h0;
  localparam logic [2:0] CPM_COP_USABLE_RESET = 3'h0;

  typedef enum logic [1:0] {CPM_MODE_KERNEL, CPM_MODE_SUPER, CPM_MODE_USER} cpm_mode_t;

  typedef struct packed {
    logic valid;
    logic [31:0] word;
    logic [63:0] src_val;
    logic [63:0] tgt_val;
  } cpm_issue_t;

  typedef struct packed {
    logic we;
    logic [4:0] idx;
    logic [63:0] data;
  } cpm_gpr_wr_t;

  typedef struct packed {
    logic rd_en;
    logic we;
    logic [1:0] cop;
    logic [4:0] idx;
    logic [63:0] data;
  } cpm_cop_req_t;

  typedef struct packed {
    logic reserved_instr;
    logic cop_unusable;
    logic [1:0] cop;
  } cpm_exc_t;
endpackage

/* File: verif/cpm_move_unit_props.sv */
// Port checker for the move unit
`timescale 1ns/1ps
module cpm_move_unit_props import cpm_pkg::*; (
  input logic clk,
  input logic reset_n,
  input cpm_issue_t issue,
  input cpm_mode_t mode,
  input logic mode64,
  input logic [2:0] cop_usable,
  input cpm_gpr_wr_t gpr_wr,
  input cpm_cop_req_t cop_req,
  input cpm_exc_t exc,
  input logic [63:0] product_upper,
  input logic [63:0] product_bottom
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic [31:0] w = issue.word;
  wire logic [1:0] z = w[27:26];
  wire logic c = issue.valid && w[31:28] == 4'h4 && z != 2'h3 && {w[25:24], w[22:21], w[10:0]} == 15'h0;
  wire logic ok = z == 2'h0 ? mode == CPM_MODE_KERNEL || cop_usable[0] : cop_usable[z];
  // Function code only while a special op is presented
  wire logic [5:0] f = issue.valid && w[31:26] == 6'h00 ? w[5:0] : 6'h3F;
  // Signed 32 x 32 product of the presented operands
  wire logic signed [63:0] sp = $signed(issue.src_val[31:0]) * $signed(issue.tgt_val[31:0]);
  lwu_trap_a: assert property (issue.valid && w[31:26] == CPM_OP_LWU && !mode64 && mode != CPM_MODE_KERNEL
    |=> exc.reserved_instr) else $error("no trap");
  cop_read_a: assert property (c && ok && !w[23] |=> cop_req.rd_en && cop_req.cop == $past(z) ##1 gpr_wr.we)
    else $error("read lost");
  unusable_a: assert property (c && !ok |=> exc.cop_unusable && exc.cop == $past(z) && !cop_req.we)
    else $error("no unusable");
  cop_write_a: assert property (c && ok && w[23] |=> cop_req.we && cop_req.data == $past(issue.tgt_val))
    else $error("write lost");
  rd_upper_a: assert property (f == CPM_FN_RD_UPPER |=> gpr_wr.we && gpr_wr.data == $past(product_upper))
    else $error("upper read");
  rd_bottom_a: assert property (f == CPM_FN_RD_BOTTOM |=> gpr_wr.we && gpr_wr.data == $past(product_bottom))
    else $error("bottom read");
  wr_upper_a: assert property (f == CPM_FN_WR_UPPER |=> product_upper[31:0] == $past(issue.src_val[31:0]))
    else $error("upper write");
  prod_low_a: assert property (f == CPM_FN_SIGNED_PRODUCT && mode64
    |=> product_bottom[31:0] == $past(issue.src_val[31:0] * issue.tgt_val[31:0])) else $error("bad product");
  prod_high_a: assert property (f == CPM_FN_SIGNED_PRODUCT && mode64
    |=> product_upper == {{32{$past(sp[63])}}, $past(sp[63:32])}) else $error("bad upper product");
  wr_bottom_a: assert property (f == CPM_FN_WR_BOTTOM |=> product_bottom == $past(issue.src_val))
    else $error("bottom write");
  cover property (c && !w[23]);
  cover property (exc.cop_unusable);
  cover property (f == CPM_FN_SIGNED_PRODUCT);
endmodule // cpm_move_unit_props

/* File: verif/cpm_cop_model.sv */
// Coprocessor register model at the far side
`timescale 1ns/1ps
module cpm_cop_model import cpm_pkg::*; (
  input logic clk,
  input cpm_cop_req_t cop_req,
  output logic [63:0] cop_rdata
);
  logic [63:0] regs_ff [4][32];
  // Writes land one edge after the request; reads answer within the request's cycle
  always @(posedge clk) begin
    if (cop_req.we) regs_ff[cop_req.cop][cop_req.idx] <= cop_req.data;
  end
  // Idle bus shows the inverse of the addressed word
  assign cop_rdata = cop_req.rd_en ? regs_ff[cop_req.cop][cop_req.idx]
    : ~regs_ff[cop_req.cop][cop_req.idx];
endmodule // cpm_cop_model

/* File: verif/cpm_move_unit_tb.sv */
// Bench for the move unit
`timescale 1ns/1ps
module cpm_move_unit_tb;
  import cpm_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, mode64 = 1'b1;
  cpm_issue_t issue = '0;
  cpm_mode_t mode = CPM_MODE_KERNEL;
  logic [2:0] cop_usable = 3'h7;
  logic [63:0] cop_rdata, product_upper, product_bottom;
  cpm_gpr_wr_t gpr_wr;
  cpm_cop_req_t cop_req;
  cpm_exc_t exc;
  int bad_count = 0, samples_checked = 0;
  cpm_move_unit i_cpm_move_unit (
    .clk(clk),
    .reset_n(reset_n),
    .issue(issue),
    .mode(mode),
    .mode64(mode64),
    .cop_usable(cop_usable),
    .cop_rdata(cop_rdata),
    .gpr_wr(gpr_wr),
    .cop_req(cop_req),
    .exc(exc),
    .product_upper(product_upper),
    .product_bottom(product_bottom)
  );
  cpm_cop_model i_cpm_cop_model (
    .clk(clk),
    .cop_req(cop_req),
    .cop_rdata(cop_rdata)
  );
  initial forever #2.5 clk = ~clk;
  task automatic final_report;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t ns: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic go(input logic [31:0] wd, input logic [63:0] s, t);
    @(posedge clk);
    issue <= '{1'b1, wd, s, t};
    @(posedge clk);
    issue.valid <= 1'b0;
    #1;
  endtask
  task automatic t_prod;
    go(32'h00000013, 64'h5A, 64'h0);
    chk(product_bottom, 64'h5A);
    go(32'h00000011, 64'hA5, 64'h0);
    chk(product_upper, 64'hA5);
    go(32'h00002810, 64'h0, 64'h0);
    chk(gpr_wr.data, 64'hA5);
    chk(gpr_wr.idx, 5);
    repeat (2) @(posedge clk);
    go(32'h00000018, 64'hFFFFFFFFFFFFFFFD, 64'h7);
    chk(product_upper, 64'hFFFFFFFFFFFFFFFF);
    chk(product_bottom, 64'hFFFFFFFFFFFFFFEB);
    go(32'h00003012, 64'h0, 64'h0);
    chk(gpr_wr.data, 64'hFFFFFFFFFFFFFFEB);
    chk(gpr_wr.idx, 6);
    repeat (2) @(posedge clk);
  endtask
  task automatic t_cop;
    go(32'h40804800, 64'h0, 64'h80000005);
    chk(cop_req.we, 1);
    chk(cop_req.idx, 9);
    go(32'h40074800, 64'h0, 64'h0);
    chk(cop_req.rd_en, 1);
    @(posedge clk) #1;
    chk(gpr_wr.data, 64'hFFFFFFFF80000005);
    chk(gpr_wr.idx, 7);
    go(32'h44801000, 64'h0, 64'h9000000100000002);
    chk(cop_req.cop, 1);
    go(32'h44081800, 64'h0, 64'h0);
    chk(cop_req.idx, 2);
    @(posedge clk) #1;
    chk(gpr_wr.data, 64'hFFFFFFFF90000001);
  endtask
  task automatic t_bad;
    @(posedge clk);
    mode <= CPM_MODE_USER;
    mode64 <= 1'b0;
    cop_usable <= 3'h0;
    go(32'h9C000000, 64'h0, 64'h0);
    chk(exc.reserved_instr, 1);
    go(32'h44801000, 64'h0, 64'h0);
    chk(exc, 4'h5);
    @(posedge clk);
    mode <= CPM_MODE_SUPER;
    go(32'h40804800, 64'h0, 64'h0);
    chk(exc, 4'h4);
    chk(cop_req.we, 0);
    @(posedge clk);
    mode <= CPM_MODE_KERNEL;
    go(32'h40804800, 64'h0, 64'h0);
    chk(exc, 4'h0);
    chk(cop_req.we, 1);
    go(32'h9C000000, 64'h0, 64'h0);
    chk(exc.reserved_instr, 0);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_prod();
    t_cop();
    t_bad();
    final_report();
  end
  initial begin
    repeat (500) @(posedge clk);
    bad_count++;
    final_report();
  end
endmodule // cpm_move_unit_tb
bind cpm_move_unit cpm_move_unit_props i_cpm_move_unit_props (
  .clk(clk),
  .reset_n(reset_n),
  .issue(issue),
  .mode(mode),
  .mode64(mode64),
  .cop_usable(cop_usable),
  .gpr_wr(gpr_wr),
  .cop_req(cop_req),
  .exc(exc),
  .product_upper(product_upper),
  .product_bottom(product_bottom)
);
